// file: inc/bir_defs.svh
// constants for the bilinear image resizer: widths, fixed point, resets
`ifndef BIR_DEFS_SVH
`define BIR_DEFS_SVH

// colour channel width; only 8 bits is a verified setting
`define BIR_DW 8
// resolution and step factor widths
`define BIR_RES_W 13
`define BIR_STEP_W 16
// fixed-point step: ten fractional bits, unity is 1024
`define BIR_FRAC 10
`define BIR_UNITY 11'h400
// accumulator width: 13 integer bits plus 10 fraction plus headroom
`define BIR_ACC_W 24
// line buffer address widths (input row, output row counter)
`define BIR_IN_AW 11
`define BIR_OUT_AW 11
// three row banks: two being read, one being written
`define BIR_NBANK 3
`define BIR_BANK_W 2
// bank rotation reset values
`define BIR_WB_RST 2'h0
`define BIR_BC_RST 2'h1
`define BIR_BP_RST 2'h2
// cycles from read issue to scaled pixel on the outputs
`define BIR_LATENCY 2

`endif

// file: inc/bir_pkg.sv
// types shared by the bilinear image resizer modules
`default_nettype none
`include "bir_defs.svh"

package bir_pkg;

  typedef logic [`BIR_RES_W-1:0] bir_res_t;
  typedef logic [`BIR_STEP_W-1:0] bir_step_t;
  typedef logic [`BIR_ACC_W-1:0] bir_acc_t;
  typedef logic [`BIR_FRAC-1:0] bir_frac_t;
  typedef logic [3*`BIR_DW-1:0] bir_pix_t;
  typedef logic [`BIR_BANK_W-1:0] bir_bank_t;

  typedef enum logic [0:0] {
    BIR_IDLE = 1'b0,
    BIR_GEN = 1'b1
  } bir_state_e;

  // whole state of the top level
  typedef struct packed {
    bir_state_e state;
    bir_res_t in_col;
    bir_res_t in_row;
    bir_bank_t wb;
    bir_bank_t bc;
    bir_bank_t bp;
    bir_res_t gen_row;
    bir_res_t out_x;
    bir_res_t out_y;
    bir_acc_t hacc;
    bir_acc_t vacc;
    bir_res_t iw;
    bir_res_t ih;
    bir_res_t ow;
    bir_res_t oh;
    bir_step_t hs;
    bir_step_t vs;
    logic upscale;
    logic overrun;
    logic v1;
    bir_frac_t fx1;
    bir_frac_t fy1;
    bir_bank_t selp1;
    bir_bank_t selc1;
  } bir_top_s;

  // whole state of the interpolator
  typedef struct packed {
    logic v;
    bir_pix_t pix;
  } bir_lerp_s;

endpackage

`default_nettype wire

// file: hw/bir_line_ram.sv
// one input row bank: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none

module bir_line_ram
  import bir_pkg::*;
(
  // clock
  input wire logic mclk,
  // write port
  input wire logic we,
  input wire logic [`BIR_IN_AW-1:0] waddr,
  input wire bir_pix_t wdata,
  // read ports
  input wire logic [`BIR_IN_AW-1:0] raddr_a,
  input wire logic [`BIR_IN_AW-1:0] raddr_b,
  output bir_pix_t rdata_a,
  output bir_pix_t rdata_b
);

  bir_pix_t mem [0:(1<<`BIR_IN_AW)-1];
  bir_pix_t rdata_a_r;
  bir_pix_t rdata_b_r;

  // no reset on the array; read data is registered for timing
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a_r <= mem[raddr_a];
    rdata_b_r <= mem[raddr_b];
  end

  assign rdata_a = rdata_a_r;
  assign rdata_b = rdata_b_r;

endmodule

`default_nettype wire

// file: hw/bir_lerp.sv
// bilinear blend of four neighbour pixels, registered output
`timescale 1ns/1ps
`default_nettype none

module bir_lerp
  import bir_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // four neighbours and weights
  input wire logic in_valid,
  input wire bir_frac_t fx,
  input wire bir_frac_t fy,
  input wire bir_pix_t p00,
  input wire bir_pix_t p01,
  input wire bir_pix_t p10,
  input wire bir_pix_t p11,
  // blended pixel
  output logic out_valid,
  output bir_pix_t out_pix
);

  bir_lerp_s st_r;
  bir_lerp_s st_nxt;
  bir_pix_t mixed;

  // a*(1-f) + b*f with f in 1/1024 units; truncates, never overflows
  function automatic logic [`BIR_DW-1:0] mix(
    input logic [`BIR_DW-1:0] a,
    input logic [`BIR_DW-1:0] b,
    input bir_frac_t f
  );
    logic [18:0] s;
    s = 19'(a) * 19'(`BIR_UNITY - 11'(f)) + 19'(b) * 19'(f);
    return s[`BIR_FRAC +: `BIR_DW];
  endfunction

  // one blend per colour channel: horizontal then vertical
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_ch
      assign mixed[c*`BIR_DW +: `BIR_DW] = mix(
        mix(p00[c*`BIR_DW +: `BIR_DW], p01[c*`BIR_DW +: `BIR_DW], fx),
        mix(p10[c*`BIR_DW +: `BIR_DW], p11[c*`BIR_DW +: `BIR_DW], fx),
        fy);
    end
  endgenerate

  // valid follows the data through the same register
  always_comb begin
    st_nxt = st_r;
    st_nxt.v = in_valid;
    if (in_valid) begin
      st_nxt.pix = mixed;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.v;
  assign out_pix = st_r.pix;

endmodule

`default_nettype wire

// file: hw/bir_top.sv
// bilinear image resizer: row banks, step accumulators, output stream
`timescale 1ns/1ps
`default_nettype none

module bir_top
  import bir_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // input pixel stream
  input wire logic in_valid,
  input wire logic [`BIR_DW-1:0] in_red,
  input wire logic [`BIR_DW-1:0] in_green,
  input wire logic [`BIR_DW-1:0] in_blue,
  // static configuration
  input wire bir_res_t input_width,
  input wire bir_res_t input_height,
  input wire bir_res_t output_width,
  input wire bir_res_t output_height,
  input wire bir_step_t horizontal_step,
  input wire bir_step_t vertical_step,
  // scaled pixel stream
  output logic out_valid,
  output logic [`BIR_DW-1:0] out_red,
  output logic [`BIR_DW-1:0] out_green,
  output logic [`BIR_DW-1:0] out_blue,
  // status
  output logic upscale_mode,
  output logic row_overrun
);

  // whole block state: one always_comb fills st_nxt, one always_ff
  // registers it, so nothing escapes the reset or the idiom
  bir_top_s st_r;
  bir_top_s st_nxt;

  // read addresses shared by all banks; every bank is read every cycle
  // and the delayed selects pick the two rows, which keeps the read
  // path free of a bank-dependent address multiplexer
  logic [`BIR_IN_AW-1:0] rd_a;
  logic [`BIR_IN_AW-1:0] rd_b;
  bir_pix_t bank_a [0:`BIR_NBANK-1];
  bir_pix_t bank_b [0:`BIR_NBANK-1];
  bir_pix_t wr_pix;
  bir_pix_t p00;
  bir_pix_t p01;
  bir_pix_t p10;
  bir_pix_t p11;
  bir_pix_t blended;

  // combinational helpers; all are decoded from registered state, the
  // current input strobe and the size inputs only, so no combinational loop can form
  // through the output side
  logic frame_start;
  logic row_done;
  bir_res_t cur_iw;
  bir_res_t cur_ih;
  bir_res_t ix;
  bir_res_t ix1;
  bir_res_t done_row;
  bir_acc_t vacc_step;

  // next bank in the three-way rotation; three banks let the next row be
  // written while the previous and current rows are still being read,
  // at the cost of one extra row of storage
  function automatic bir_bank_t bank_next(input bir_bank_t b);
    return (b == 2'h2) ? 2'h0 : b + 2'h1;
  endfunction

  // integer part of a fixed-point accumulator
  // the headroom bits above a 13-bit size are dropped on purpose
  function automatic bir_res_t acc_int(input bir_acc_t a);
    return a[`BIR_FRAC +: `BIR_RES_W];
  endfunction

  // last position of a count of the given size; used for columns, rows
  // and output pixels alike, so the three end tests cannot drift apart
  function automatic logic at_last(input bir_res_t pos, input bir_res_t n);
    return pos == n - 13'h1;
  endfunction

  // channels packed red high, blue low; captured only with valid
  // the bank write enable, not this word, carries the valid qualifier
  assign wr_pix = {in_red, in_green, in_blue};

  // frame begins with the first valid pixel of row 0
  // limitation: a source that drops pixels stays misaligned even after its
  // counts wrap; a reset realigns the frame at once
  assign frame_start = in_valid && (st_r.in_row == '0) &&
                       (st_r.in_col == '0);
  // sizes in force this cycle; new values apply from a frame start
  assign cur_iw = frame_start ? input_width : st_r.iw;
  assign cur_ih = frame_start ? input_height : st_r.ih;
  assign row_done = in_valid && at_last(st_r.in_col, cur_iw);
  assign done_row = st_r.in_row;

  // horizontal neighbours, right one clamped at the row end
  // the clamp repeats the last column rather than reading a stale word
  // left over in the bank from a wider earlier frame
  assign ix = acc_int(st_r.hacc);
  assign ix1 = (ix + 13'h1 >= st_r.iw) ? ix : ix + 13'h1;
  assign rd_a = ix[`BIR_IN_AW-1:0];
  assign rd_b = ix1[`BIR_IN_AW-1:0];

  // three row banks; the writer never touches the two being read
  // the row width is bounded by the bank depth, so the input row buffer
  // must be sized for the widest input row in use
  genvar g;
  generate
    for (g = 0; g < `BIR_NBANK; g++) begin : g_bank
      bir_line_ram u_ram (
        .mclk(mclk),
        .we(in_valid && (st_r.wb == 2'(g))),
        .waddr(st_r.in_col[`BIR_IN_AW-1:0]),
        .wdata(wr_pix),
        .raddr_a(rd_a),
        .raddr_b(rd_b),
        .rdata_a(bank_a[g]),
        .rdata_b(bank_b[g])
      );
    end
  endgenerate

  // bank selects are delayed with the read so a rotation is harmless
  // even when it falls between the read issue and the data return
  assign p00 = bank_a[st_r.selp1];
  assign p01 = bank_b[st_r.selp1];
  assign p10 = bank_a[st_r.selc1];
  assign p11 = bank_b[st_r.selc1];

  // four-neighbour blend, registered; together with the bank read this
  // puts the first scaled pixel three edges after the row end
  bir_lerp u_lerp (
    .mclk(mclk),
    .reset(reset),
    .in_valid(st_r.v1),
    .fx(st_r.fx1),
    .fy(st_r.fy1),
    .p00(p00),
    .p01(p01),
    .p10(p10),
    .p11(p11),
    .out_valid(out_valid),
    .out_pix(blended)
  );

  // next state: input side, output row generation, row hand-over
  // later blocks override earlier ones on purpose: a row end or a frame
  // start takes priority over the running generation
  always_comb begin
    st_nxt = st_r;
    st_nxt.v1 = 1'b0;
    st_nxt.overrun = 1'b0;
    vacc_step = st_r.vacc + bir_acc_t'(st_r.vs);

    // latch sizes and steps once per frame, so a mid-frame change
    // cannot tear the image
    if (frame_start) begin
      st_nxt.iw = input_width;
      st_nxt.ih = input_height;
      st_nxt.ow = output_width;
      st_nxt.oh = output_height;
      st_nxt.hs = horizontal_step;
      st_nxt.vs = vertical_step;
      // enlarge if either output dimension reaches the input's
      st_nxt.upscale = (output_width >= input_width) ||
                       (output_height >= input_height);
    end

    // one output pixel per clock while a row is generated
    case (st_r.state)
      BIR_IDLE: begin
        st_nxt.out_x = '0;
      end
      BIR_GEN: begin
        st_nxt.v1 = 1'b1;
        st_nxt.fx1 = st_r.hacc[`BIR_FRAC-1:0];
        st_nxt.fy1 = st_r.vacc[`BIR_FRAC-1:0];
        st_nxt.selp1 = st_r.bp;
        st_nxt.selc1 = st_r.bc;
        if (at_last(st_r.out_x, st_r.ow)) begin
          // row finished: step vertically, repeat while still between
          // the same two input rows (enlargement)
          st_nxt.out_x = '0;
          st_nxt.hacc = '0;
          st_nxt.out_y = st_r.out_y + 13'h1;
          st_nxt.vacc = vacc_step;
          if ((acc_int(vacc_step) == st_r.gen_row) &&
              (st_r.out_y + 13'h1 < st_r.oh)) begin
            st_nxt.state = BIR_GEN;
          end else begin
            st_nxt.state = BIR_IDLE;
          end
        end else begin
          st_nxt.out_x = st_r.out_x + 13'h1;
          st_nxt.hacc = st_r.hacc + bir_acc_t'(st_r.hs);
        end
      end
      default: begin
        st_nxt.state = BIR_IDLE;
      end
    endcase

    // output row and vertical accumulator restart with each frame;
    // a row still running at that point is cut short
    if (frame_start) begin
      st_nxt.out_y = '0;
      st_nxt.vacc = '0;
      st_nxt.out_x = '0;
      st_nxt.hacc = '0;
      if (st_r.state == BIR_GEN) begin
        st_nxt.overrun = 1'b1;
        st_nxt.state = BIR_IDLE;
      end
    end

    // input column and row counting, one pixel per clock
    if (in_valid) begin
      st_nxt.in_col = st_r.in_col + 13'h1;
    end
    if (row_done) begin
      st_nxt.in_col = '0;
      st_nxt.in_row = at_last(st_r.in_row, cur_ih) ? '0 :
                      st_r.in_row + 13'h1;
      // rotate banks: written row becomes current, current becomes
      // previous; keeps running across frames so banks never collide
      st_nxt.bp = st_r.bc;
      st_nxt.bc = st_r.wb;
      st_nxt.wb = bank_next(st_r.wb);
      // blanking too short for enlargement: the old row is dropped
      // rather than read from a bank that is now being rewritten
      if ((st_nxt.state == BIR_GEN) && (st_nxt.out_x != '0)) begin
        st_nxt.overrun = 1'b1;
      end
      // start every output row that lies between the last two rows
      if ((done_row != '0) && (st_nxt.out_y < st_nxt.oh) &&
          (acc_int(st_nxt.vacc) == done_row - 13'h1)) begin
        st_nxt.state = BIR_GEN;
        st_nxt.gen_row = done_row - 13'h1;
      end else begin
        st_nxt.state = BIR_IDLE;
      end
      st_nxt.out_x = '0;
      st_nxt.hacc = '0;
    end
  end

  // synchronous reset clears every state bit, banks start distinct
  // the bank contents are not cleared; no row is read before it has
  // been written once after reset, so stale words never reach the blend
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
      st_r.wb <= `BIR_WB_RST;
      st_r.bc <= `BIR_BC_RST;
      st_r.bp <= `BIR_BP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from registers
  // channel width follows the shared constant; only 8 bits is verified
  assign out_red = blended[2*`BIR_DW +: `BIR_DW];
  assign out_green = blended[`BIR_DW +: `BIR_DW];
  assign out_blue = blended[0 +: `BIR_DW];
  assign upscale_mode = st_r.upscale;
  assign row_overrun = st_r.overrun;

endmodule

`default_nettype wire

// file: test/bir_video_src.sv
// upstream pixel source model for the resizer bench
`timescale 1ns/1ps
`default_nettype none

module bir_video_src (
  // clock and command
  input wire logic mclk,
  input wire logic go,
  input wire logic [12:0] cols,
  input wire logic [12:0] rows,
  input wire logic [7:0] gap,
  // pixel stream
  output logic busy,
  output logic in_valid,
  output logic [7:0] in_red,
  output logic [7:0] in_green,
  output logic [7:0] in_blue
);
  int r;
  int c;
  int g;

  // one raster frame per go; idle cycles carry junk so stale data never helps
  initial begin
    {busy, in_valid, in_red, in_green, in_blue} = '0;
    forever begin
      @(posedge mclk);
      if (go) begin
        busy <= 1'b1;
        for (r = 0; r < rows; r++) begin
          for (c = 0; c < cols; c++) begin
            in_valid <= 1'b1;
            in_red <= 8'(r * 61 + c * 29);
            in_green <= 8'(r * 17 + c * 83 + 5);
            in_blue <= 8'(255 - r * 43 - c * 11);
            @(posedge mclk);
          end
          for (g = 0; g < gap; g++) begin
            in_valid <= 1'b0;
            {in_red, in_green, in_blue} <= ~{in_red, in_green, in_blue};
            @(posedge mclk);
          end
        end
        in_valid <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// file: test/bir_top_sva.sv
// concurrent checks on the resizer's ports
`timescale 1ns/1ps
`default_nettype none
`include "bir_defs.svh"

module bir_top_sva
  import bir_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // input side
  input wire logic in_valid,
  input wire bir_res_t input_width,
  input wire bir_res_t input_height,
  input wire bir_res_t output_width,
  input wire bir_res_t output_height,
  // output side
  input wire logic out_valid,
  input wire logic [`BIR_DW-1:0] out_red,
  input wire logic [`BIR_DW-1:0] out_green,
  input wire logic [`BIR_DW-1:0] out_blue,
  input wire logic upscale_mode,
  input wire logic row_overrun
);
  bir_res_t cnt_r;
  logic cut_r;

  // pixels into the current output row; a cut row makes the count meaningless
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
      cut_r <= 1'b0;
    end else begin
      if (out_valid)
        cnt_r <= (cnt_r + 13'h1 == output_width) ? 13'h0 : cnt_r + 13'h1;
      if (row_overrun)
        cut_r <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_rise;
    !out_valid ##1 out_valid;
  endsequence
  sequence s_release;
    reset ##1 !reset;
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0)
    reset |=> !out_valid && !row_overrun && !upscale_mode
      && {out_red, out_green, out_blue} == 24'h0)
    else $error("outputs not cleared by reset");
  release_quiet_a: assert property (disable iff (1'b0)
    s_release |-> !out_valid [*3])
    else $error("output valid too soon after reset");
  mode_hold_a: assert property (
    !$past(reset) && $changed(upscale_mode) |-> $past(in_valid))
    else $error("mode changed without a frame start");
  mode_value_a: assert property (
    !$past(reset) && $changed(upscale_mode) |-> upscale_mode ==
      (output_width >= input_width || output_height >= input_height))
    else $error("mode differs from size comparison");
  rise_cause_a: assert property (
    s_rise |-> $past(in_valid, 3))
    else $error("output row began without a row end");
  row_whole_a: assert property (
    !cut_r && $fell(out_valid) |-> cnt_r == 13'h0)
    else $error("output row length wrong");
  ovr_cause_a: assert property (
    row_overrun |-> $past(in_valid))
    else $error("overrun without an input pixel");
  ovr_pulse_a: assert property (
    row_overrun |=> !row_overrun)
    else $error("overrun pulse too long");
endmodule

bind bir_top bir_top_sva i_sva (
  .mclk(mclk), .reset(reset), .in_valid(in_valid),
  .input_width(input_width), .input_height(input_height),
  .output_width(output_width), .output_height(output_height),
  .out_valid(out_valid), .out_red(out_red), .out_green(out_green),
  .out_blue(out_blue), .upscale_mode(upscale_mode),
  .row_overrun(row_overrun)
);

`default_nettype wire

// file: test/bir_top_bench.sv
// self-checking bench: frames up, down, overrun, reset mid-frame
`timescale 1ns/1ps
`default_nettype none

module bir_top_bench
  import bir_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic [7:0] gap = 8'h0;
  bir_res_t iw = 13'h4, ih = 13'h3, ow = 13'h6, oh = 13'h4;
  bir_step_t hs = 16'h0, vs = 16'h0;
  logic busy, in_valid, out_valid, upscale_mode, row_overrun;
  logic [7:0] in_red, in_green, in_blue, out_red, out_green, out_blue;
  logic [23:0] img [0:7][0:7]; // frames fit both dimensions; the 8-wide frame fills every column
  int n_mismatch = 0, num_checks = 0, n_ovr = 0, n_out = 0;
  int mr = 0, mc = 0, ox = 0, oy = 0;
  bit chk_en = 1'b1;

  // one clock serves pixel and core side alike
  always #2 mclk = ~mclk;

  bir_video_src i_src (
    .mclk(mclk), .go(go), .cols(iw), .rows(ih), .gap(gap), .busy(busy),
    .in_valid(in_valid), .in_red(in_red), .in_green(in_green),
    .in_blue(in_blue));

  bir_top i_dut (
    .mclk(mclk), .reset(reset), .in_valid(in_valid), .in_red(in_red),
    .in_green(in_green), .in_blue(in_blue), .input_width(iw),
    .input_height(ih), .output_width(ow), .output_height(oh),
    .horizontal_step(hs), .vertical_step(vs), .out_valid(out_valid),
    .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
    .upscale_mode(upscale_mode), .row_overrun(row_overrun));

  task automatic check(input string nm, input logic [23:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic int mix(int a, int b, int f);
    return (a * (1024 - f) + b * f) >> 10;
  endfunction

  // reference blend of the four neighbours, truncating like the hardware
  function automatic logic [23:0] exp_pix(int x, int y);
    int c0, c1, r0, fx, fy, k, a, b;
    logic [23:0] e;
    c0 = x * hs >> 10;
    fx = x * hs & 1023;
    c1 = (c0 + 1 < iw) ? c0 + 1 : iw - 1;
    r0 = y * vs >> 10;
    fy = y * vs & 1023;
    for (k = 0; k < 3; k++) begin
      a = mix(img[r0][c0][k*8+:8], img[r0][c1][k*8+:8], fx);
      b = mix(img[r0+1][c0][k*8+:8], img[r0+1][c1][k*8+:8], fx);
      e[k*8+:8] = 8'(mix(a, b, fy));
    end
    return e;
  endfunction

  // record the pixels taken and compare every scaled pixel while chk_en is set
  always @(posedge mclk) begin
    if (!reset && in_valid) begin
      img[mr][mc] = {in_red, in_green, in_blue};
      mc = (mc + 1 == iw) ? 0 : mc + 1;
      if (mc == 0)
        mr++;
    end
    if (!reset && out_valid && chk_en) begin
      check("out_pix", {out_red, out_green, out_blue}, exp_pix(ox, oy));
      n_out++;
      ox = (ox + 1 == ow) ? 0 : ox + 1;
      if (ox == 0)
        oy++;
    end
    if (row_overrun)
      n_ovr++;
  end

  // sizes change only between frames, as the driver is advised to do
  task automatic frame(input int w, h, x, y, gp);
    int k;
    @(posedge mclk);
    {iw, ih, ow, oh} <= {13'(w), 13'(h), 13'(x), 13'(y)};
    hs <= 16'((w - 1) * 1024 / x);
    vs <= 16'((h - 1) * 1024 / y);
    gap <= 8'(gp);
    {mr, mc, ox, oy, n_out} = '0;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (k = 0; k < 5000 && busy; k++)
      @(posedge mclk);
    repeat (40) @(posedge mclk);
    if (chk_en) begin
      check("pixel_count", 24'(n_out), 24'(x * y));
      check("upscale_mode", 24'(upscale_mode), 24'(x >= w || y >= h));
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("reset_out", {out_valid, upscale_mode, out_red}, 24'h0);
    frame(4, 3, 6, 4, 20);
    $display("test upscale done");
    frame(8, 6, 4, 3, 20);
    $display("test downscale done");
    chk_en = 1'b0;
    frame(4, 3, 6, 4, 0);
    check("overrun_seen", 24'(n_ovr > 0), 24'h1);
    $display("test back to back rows done");
    fork
      frame(4, 3, 6, 4, 20);
      begin
        repeat (60) @(posedge mclk);
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check("mid_reset", {out_valid, row_overrun, out_blue}, 24'h0);
      end
    join
    chk_en = 1'b1;
    frame(4, 3, 6, 4, 20);
    $display("test reset mid frame done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
